//--- inc/adc_spi_pkg.sv
// Purpose: shared constants and carriers for the converter serial port
// Assumes: 8-bit register addresses and data, MSB-first serial fields
// Notes: CRC polynomial and seed are plain defaults
package adc_spi_pkg;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_READ = 8'h10;
  localparam logic [7:0] OP_WRITE = 8'h08;
  localparam logic [7:0] OP_SET = 8'h18;
  localparam logic [7:0] OP_CLEAR = 8'h20;
  localparam logic [1:0] TAIL_NONE = 2'h0;
  localparam logic [1:0] TAIL_TAG = 2'h1;
  localparam logic [1:0] TAIL_FLAGS = 2'h2;
  localparam logic [1:0] SHAPE_RESET = 2'h0;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [4:0] CRC_LEN_REG = 5'h08;
  localparam logic [4:0] CRC_LEN_RES = 5'h10;
  localparam logic [4:0] CRC_LEN_FULL = 5'h18;
  localparam logic [6:0] DAISY_DELAY = 7'h18;
  localparam logic [6:0] FRAME_BITS = 7'h20;
  localparam logic [6:0] LAUNCH_MAX = 7'h7F;
  localparam logic [5:0] CMD_BITS = 6'h18;
  localparam logic [5:0] CRC_CMD_BITS = 6'h20;
  localparam logic [5:0] CAP_MAX = 6'h3F;
  localparam logic FLAG_LEAD = 1'b1;
  localparam logic [7:0] OPEN_ADDR_MAX = 8'h01;
  localparam logic [2:0] CS_SYNC_RESET = 3'h7;

  typedef struct packed {
    logic crc_en;
    logic [1:0] tail_sel;
    logic averaging;
    logic fixed_pattern;
    logic [1:0] clock_shape;
  } frame_cfg_t;

  typedef struct packed {
    logic [19:0] value;
    logic [3:0] channel_tag;
  } conv_result_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;
endpackage

//--- rtl/adc_spi_port.sv
// Purpose: serial host port: output frames, command decode, daisy chain
// Assumes: host keeps chip select high for >= 6 i_clk and waits
//   >= 4 i_clk after its fall before the first serial clock edge
// Notes: conversion engine and register map sit outside this block
`timescale 1ns/1ps

module adc_spi_port
  import adc_spi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire frame_cfg_t i_cfg,
  input wire conv_result_t i_result,
  input wire logic i_test_voltage_connect,
  input wire logic i_walking_bit_test_enable,
  input wire logic i_check_error_clear,
  input wire logic [7:0] i_rd_data,
  output logic [7:0] o_rd_addr,
  output reg_wr_t o_reg_wr,
  output logic o_input_check_error,
  output logic o_test_switch_on,
  output logic o_result_from_walking,
  output logic o_conv_start
);

  function automatic logic [7:0] crc8(input logic [23:0] d,
                                      input logic [4:0] n);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 0; i < 24; i++) begin
      if (i < int'(n)) begin
        fb = c[7] ^ d[23 - i];
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction

  // Core-domain state read by the link side; held while a frame runs
  logic [1:0] shape_q;
  logic [31:0] word_q;
  logic daisy_ok_q;

  // Link-domain state read by the core only after chip select rises
  logic [31:0] rx_q;
  logic [5:0] rx_cnt_q;
  logic fresh_q;
  logic [6:0] launch_q;
  logic frame_tog_q;

  logic cap_clk;
  logic [6:0] idx;

  // Capture edge is always the rising edge of cap_clk. The inversion
  // only moves between frames, so the mux cannot glitch mid-transfer.
  assign cap_clk = i_sclk ^ (shape_q[1] ^ shape_q[0]);

  always_ff @(posedge cap_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_q <= 32'h0000_0000;
    end else begin
      rx_q <= {rx_q[30:0], i_sdi};
    end
  end

  always_ff @(posedge cap_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_cnt_q <= 6'h00;
    end else if (fresh_q) begin
      rx_cnt_q <= 6'h01;
    end else if (rx_cnt_q != CAP_MAX) begin
      rx_cnt_q <= rx_cnt_q + 6'h01;
    end
  end

  // Marks a frame with no capture yet; count survives chip select rise
  always_ff @(posedge cap_clk or posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fresh_q <= 1'b1;
    end else if (i_cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // Flips at the first capture of each frame, so the core can tell a
  // clocked frame from a bare select pulse. Edges while deselected
  // (idle level or mode changes) must not count as a frame.
  always_ff @(posedge cap_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_tog_q <= 1'b0;
    end else if (fresh_q && !i_cs_n) begin
      frame_tog_q <= !frame_tog_q;
    end
  end

  always_ff @(negedge cap_clk or posedge i_cs_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      launch_q <= 7'h00;
    end else if (i_cs_n) begin
      launch_q <= 7'h00;
    end else if (launch_q != LAUNCH_MAX) begin
      launch_q <= launch_q + 7'h01;
    end
  end

  // Modes whose first edge launches spend that edge on bit 0
  always_comb begin
    idx = launch_q;
    if (shape_q[0] && launch_q != 7'h00) begin
      idx = launch_q - 7'h01;
    end
  end

  // First bit must stand before any serial edge, hence no output flop
  always_comb begin
    o_sdo = 1'b0;
    if (!i_cs_n) begin
      if (idx >= DAISY_DELAY && daisy_ok_q) begin
        o_sdo = rx_q[23];
      end else if (idx < FRAME_BITS) begin
        o_sdo = word_q[5'(31 - idx)];
      end
    end
  end

  assign o_sdo_oe = !i_cs_n;

  // Chip select crossing: three stages, change taken once 2 and 3 agree
  logic [2:0] cs_s_q;
  logic cs_filt_q;
  logic cs_rise;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s_q <= CS_SYNC_RESET;
    end else begin
      cs_s_q <= {cs_s_q[1:0], i_cs_n};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_filt_q <= 1'b1;
    end else if (cs_s_q[1] == cs_s_q[2]) begin
      cs_filt_q <= cs_s_q[2];
    end
  end

  assign cs_rise = cs_s_q[1] && cs_s_q[2] && !cs_filt_q;

  // Command decode at frame end
  logic have_cmd;
  logic crc_ok;
  logic [23:0] cmd;
  logic seen_tog_q;
  logic new_frame;

  // Toggle is steady once chip select is high, so it is read at cs_rise only
  assign new_frame = frame_tog_q != seen_tog_q;

  always_comb begin
    cmd = i_cfg.crc_en ? rx_q[31:8] : rx_q[23:0];
    crc_ok = !i_cfg.crc_en || crc8(rx_q[31:8], CRC_LEN_FULL) == rx_q[7:0];
    if (i_cfg.crc_en) begin
      have_cmd = new_frame && rx_cnt_q == CRC_CMD_BITS;
    end else begin
      have_cmd = new_frame && rx_cnt_q >= CMD_BITS;
    end
  end

  logic [23:0] cmd_q;
  logic exec_q;
  logic err_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_q <= 24'h00_0000;
      exec_q <= 1'b0;
    end else begin
      exec_q <= cs_rise && have_cmd && crc_ok;
      if (cs_rise && have_cmd) begin
        cmd_q <= cmd;
      end
    end
  end

  // Remembers the last decoded frame, so a later select pulse without
  // serial clocks cannot replay the previous command
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_tog_q <= 1'b0;
    end else if (cs_rise) begin
      seen_tog_q <= frame_tog_q;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_q <= 1'b0;
    end else if (cs_rise && have_cmd && !crc_ok) begin
      err_q <= 1'b1;
    end else if (i_check_error_clear) begin
      err_q <= 1'b0;
    end
  end

  assign o_input_check_error = err_q;
  assign o_rd_addr = cmd_q[15:8];

  logic wr_open;
  assign wr_open = !err_q || cmd_q[15:8] <= OPEN_ADDR_MAX;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_wr <= '0;
    end else begin
      o_reg_wr.valid <= 1'b0;
      o_reg_wr.addr <= cmd_q[15:8];
      if (exec_q && wr_open) begin
        unique case (cmd_q[23:16])
          OP_WRITE: begin
            o_reg_wr.valid <= 1'b1;
            o_reg_wr.data <= cmd_q[7:0];
          end
          OP_SET: begin
            o_reg_wr.valid <= 1'b1;
            o_reg_wr.data <= i_rd_data | cmd_q[7:0];
          end
          OP_CLEAR: begin
            o_reg_wr.valid <= 1'b1;
            o_reg_wr.data <= i_rd_data & ~cmd_q[7:0];
          end
          default: begin
            o_reg_wr.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // A read answer lasts one frame; a new command may ride along
  logic rd_pend_q;
  logic [7:0] rd_data_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_pend_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (exec_q && cmd_q[23:16] == OP_READ) begin
      rd_pend_q <= 1'b1;
      rd_data_q <= i_rd_data;
    end else if (cs_rise) begin
      rd_pend_q <= 1'b0;
    end
  end

  // Conversion starts at every frame end; its mode flags travel with it
  logic vflag_q;
  logic wflag_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv_start <= 1'b0;
      vflag_q <= 1'b0;
      wflag_q <= 1'b0;
    end else begin
      o_conv_start <= cs_rise;
      if (cs_rise) begin
        vflag_q <= i_test_voltage_connect;
        wflag_q <= i_walking_bit_test_enable;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_test_switch_on <= 1'b0;
      o_result_from_walking <= 1'b0;
    end else begin
      o_test_switch_on <= i_test_voltage_connect;
      o_result_from_walking <= i_walking_bit_test_enable;
    end
  end

  // Output frame assembly
  logic [3:0] flags;
  logic [3:0] tail;
  logic has_tail;
  logic [23:0] payload;
  logic [31:0] word_d;

  always_comb begin
    flags = {FLAG_LEAD, vflag_q, err_q, wflag_q};
    has_tail = i_cfg.tail_sel == TAIL_TAG || i_cfg.tail_sel == TAIL_FLAGS;
    tail = 4'h0;
    if (i_cfg.tail_sel == TAIL_TAG) begin
      tail = i_result.channel_tag;
    end else if (i_cfg.tail_sel == TAIL_FLAGS && !i_cfg.fixed_pattern) begin
      tail = flags;
    end
    if (i_cfg.averaging) begin
      payload = {i_result.value, tail};
    end else begin
      payload = {i_result.value[19:4], tail, 4'h0};
    end
    if (rd_pend_q) begin
      if (i_cfg.crc_en) begin
        word_d = {rd_data_q, crc8({rd_data_q, 16'h0000}, CRC_LEN_REG),
                  16'h0000};
      end else begin
        word_d = {rd_data_q, 24'h00_0000};
      end
    end else if (!i_cfg.crc_en) begin
      word_d = {payload, 8'h00};
    end else if (!i_cfg.averaging && !has_tail) begin
      word_d = {payload[23:8], crc8(payload, CRC_LEN_RES), 8'h00};
    end else begin
      word_d = {payload, crc8(payload, CRC_LEN_FULL)};
    end
  end

  // Refreshed only between frames so the link sees a steady word
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_q <= 32'h0000_0000;
      shape_q <= SHAPE_RESET;
      daisy_ok_q <= 1'b1;
    end else if (cs_filt_q && !cs_rise) begin
      word_q <= word_d;
      shape_q <= i_cfg.clock_shape;
      daisy_ok_q <= !(i_cfg.tail_sel != TAIL_NONE && i_cfg.crc_en);
    end
  end

endmodule

//--- tb/adc_spi_checker.sv
// Purpose: timing checks on the serial port outputs
// Assumes: host keeps the documented frame spacing
// Notes: bound into every port instance
`timescale 1ns/1ps
module adc_spi_checker
  import adc_spi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  input wire logic i_test_voltage_connect,
  input wire logic i_walking_bit_test_enable,
  input wire logic i_check_error_clear,
  input wire reg_wr_t o_reg_wr,
  input wire logic o_input_check_error,
  input wire logic o_test_switch_on,
  input wire logic o_result_from_walking,
  input wire logic o_conv_start
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Chip select is synchronised, so frame end is seen a few cycles late
  sequence s_frame_end;
    $rose(i_cs_n) ##1 i_cs_n [*2];
  endsequence
  property p_idle;
    i_cs_n |-> !o_sdo && !o_sdo_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("sdo busy idle");
  property p_oe;
    !i_cs_n |-> o_sdo_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("sdo not driven");
  property p_tsw;
    1 |=> o_test_switch_on == $past(i_test_voltage_connect);
  endproperty
  a_tsw: assert property (p_tsw) else $error("switch wrong");
  property p_walk;
    1 |=> o_result_from_walking == $past(i_walking_bit_test_enable);
  endproperty
  a_walk: assert property (p_walk) else $error("walk wrong");
  property p_wr_one;
    o_reg_wr.valid |=> !o_reg_wr.valid;
  endproperty
  a_wr_one: assert property (p_wr_one) else $error("write long");
  property p_wr_cs;
    o_reg_wr.valid |-> $past(i_cs_n) && $past(i_cs_n, 4);
  endproperty
  a_wr_cs: assert property (p_wr_cs) else $error("write early");
  property p_conv;
    s_frame_end |-> ##[0:4] o_conv_start;
  endproperty
  a_conv: assert property (p_conv) else $error("no start");
  property p_conv_one;
    o_conv_start |=> !o_conv_start;
  endproperty
  a_conv_one: assert property (p_conv_one) else $error("start long");
  property p_block;
    o_reg_wr.valid && $past(o_input_check_error)
      |-> o_reg_wr.addr <= OPEN_ADDR_MAX;
  endproperty
  a_block: assert property (p_block) else $error("write leaked");
  property p_err_fall;
    $fell(o_input_check_error) |-> $past(i_check_error_clear);
  endproperty
  a_err_fall: assert property (p_err_fall) else $error("error lost");
endmodule

bind adc_spi_port adc_spi_checker chk (.i_clk, .i_rst_n, .i_cs_n,
  .o_sdo, .o_sdo_oe, .i_test_voltage_connect, .i_walking_bit_test_enable,
  .i_check_error_clear, .o_reg_wr, .o_input_check_error,
  .o_test_switch_on, .o_result_from_walking, .o_conv_start);

//--- tb/host_spi_model.sv
// Purpose: host controller driving whole 32-clock frames
// Assumes: 32 ns serial clock, still between frames
// Notes: data line is inverted once released
`timescale 1ns/1ps
module host_spi_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  task automatic xfer(input logic [1:0] shp, input logic [31:0] tx,
    output logic [31:0] rx);
    logic lead;
    // Modes 00 and 10 capture on the first edge after select
    lead = !shp[0];
    o_sclk = shp[1];
    #40 o_cs_n = 1'b0;
    #50;
    for (int i = 31; i >= 0; i--) begin
      if (lead) o_sdi = tx[i];
      #16 o_sclk = ~o_sclk;
      if (lead) rx[i] = i_sdo;
      else o_sdi = tx[i];
      #16 o_sclk = ~o_sclk;
      if (!lead) rx[i] = i_sdo;
    end
    #16 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #100;
  endtask
  // Select pulse with no serial clock at all
  task automatic pulse();
    #40 o_cs_n = 1'b0;
    #200 o_cs_n = 1'b1;
    #100;
  endtask
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for the serial port
// Assumes: result word held constant, map modelled here
// Notes: daisy bytes carry a marker byte when CRC is off
`timescale 1ns/1ps
module tb_top;
  import adc_spi_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_sclk, i_cs_n, i_sdi, o_sdo, o_sdo_oe;
  frame_cfg_t i_cfg = '0;
  conv_result_t i_result = {20'hA5C3E, 4'h9};
  logic i_test_voltage_connect = 1'b0;
  logic i_walking_bit_test_enable = 1'b0;
  logic i_check_error_clear = 1'b0;
  logic [7:0] i_rd_data, o_rd_addr;
  reg_wr_t o_reg_wr;
  logic o_input_check_error, o_test_switch_on, o_result_from_walking;
  logic o_conv_start, exp_err = 1'b0;
  logic [7:0] regs [256];
  logic [31:0] rx;
  int num_errors = 0;
  int cmp_count = 0;
  int wr_count = 0;
  int wr_base = 0;
  logic [8:0] rows [13] = '{9'h000, 9'h040, 9'h082, 9'h0C0, 9'h0E0,
    9'h060, 9'h0A1, 9'h100, 9'h140, 9'h1A3, 9'h190, 9'h120, 9'h160};
  assign i_rd_data = regs[o_rd_addr];
  always @(posedge i_clk)
    if (o_reg_wr.valid) begin
      regs[o_reg_wr.addr] <= o_reg_wr.data;
      wr_count++;
    end
  adc_spi_port dut (.i_clk, .i_rst_n, .i_sclk, .i_cs_n, .i_sdi, .o_sdo,
    .o_sdo_oe, .i_cfg, .i_result, .i_test_voltage_connect,
    .i_walking_bit_test_enable, .i_check_error_clear, .i_rd_data,
    .o_rd_addr, .o_reg_wr, .o_input_check_error, .o_test_switch_on,
    .o_result_from_walking, .o_conv_start);
  host_spi_model host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi),
    .i_sdo(o_sdo));
  initial forever #5 i_clk = ~i_clk;
  task final_report;
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounds the whole run so a stuck frame cannot hang it
  initial begin
    #500us;
    num_errors++;
    final_report();
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] d, input int n);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = n - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] expw();
    logic [3:0] t;
    logic [23:0] p;
    logic [31:0] w;
    frame_cfg_t c;
    c = i_cfg;
    t = c.tail_sel == TAIL_TAG ? i_result.channel_tag : 4'h0;
    if (c.tail_sel == TAIL_FLAGS && !c.fixed_pattern)
      t = {FLAG_LEAD, i_test_voltage_connect, exp_err,
        i_walking_bit_test_enable};
    p = c.averaging ? {i_result.value, t}
      : {i_result.value[19:4], t, 4'h0};
    w = {p, c.crc_en ? crc8(p, 24) : 8'h00};
    if (c.crc_en && !c.averaging && c.tail_sel[0] == c.tail_sel[1])
      w = {p[23:8], crc8({8'h00, p[23:8]}, 16), 8'h00};
    if (!(c.crc_en && c.tail_sel != TAIL_NONE))
      w[7:0] = c.crc_en ? 8'h00 : 8'hA5;
    return w;
  endfunction
  task setup(input logic [6:0] c, input logic v, input logic w);
    @(posedge i_clk);
    i_cfg <= c;
    i_test_voltage_connect <= v;
    i_walking_bit_test_enable <= w;
    repeat (4) @(posedge i_clk);
  endtask
  task frame(input logic [23:0] cmd, output logic [31:0] r);
    host.xfer(i_cfg.clock_shape,
      i_cfg.crc_en ? {cmd, crc8(cmd, 24)} : {8'hA5, cmd}, r);
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] r;
    frame({OP_READ, a, 8'h00}, r);
    frame(24'h0, r);
    cmp(r, {v, i_cfg.crc_en ? crc8({16'h0, v}, 8) : 8'h00, 8'h00,
      i_cfg.crc_en ? 8'h00 : 8'hA5});
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    cmp(32'({o_reg_wr.valid, o_input_check_error, o_sdo, o_sdo_oe,
      o_conv_start}), 32'h0);
    foreach (rows[k]) begin
      setup(rows[k][8:2], rows[k][1], rows[k][0]);
      frame(24'h0, rx);
      frame(24'h0, rx);
      cmp(rx, expw());
    end
    setup(7'h00, 1'b0, 1'b0);
    frame({OP_WRITE, 8'h05, 8'h3C}, rx);
    rdchk(8'h05, 8'h3C);
    frame({OP_SET, 8'h05, 8'h81}, rx);
    rdchk(8'h05, 8'hBD);
    frame({OP_CLEAR, 8'h05, 8'h0C}, rx);
    rdchk(8'h05, 8'hB1);
    for (int s = 1; s < 4; s++) begin
      setup({5'h00, 2'(s)}, 1'b0, 1'b0);
      frame({OP_WRITE, 8'h06, 8'(s)}, rx);
      rdchk(8'h06, 8'(s));
    end
    setup(7'h40, 1'b0, 1'b0);
    rdchk(8'h05, 8'hB1);
    host.xfer(2'h0, {OP_WRITE, 8'h05, 8'h00, ~crc8({OP_WRITE, 8'h05,
      8'h00}, 24)}, rx);
    exp_err = 1'b1;
    cmp(32'(o_input_check_error), 32'h1);
    frame({OP_WRITE, 8'h05, 8'h11}, rx);
    frame({OP_WRITE, 8'h01, 8'h22}, rx);
    rdchk(8'h05, 8'hB1);
    rdchk(8'h01, 8'h22);
    setup(7'h60, 1'b0, 1'b0);
    frame(24'h0, rx);
    frame(24'h0, rx);
    cmp(rx, expw());
    @(posedge i_clk);
    i_check_error_clear <= 1'b1;
    @(posedge i_clk);
    i_check_error_clear <= 1'b0;
    repeat (2) @(posedge i_clk);
    cmp(32'(o_input_check_error), 32'h0);
    setup(7'h40, 1'b0, 1'b0);
    frame({OP_WRITE, 8'h05, 8'h77}, rx);
    rdchk(8'h05, 8'h77);
    wr_base = wr_count;
    frame({OP_WRITE, 8'h07, 8'h5A}, rx);
    host.pulse();
    cmp(32'(wr_count - wr_base), 32'h1);
    final_report();
  end
endmodule
